// *** core/arith_cfg.svh ***
// Timing counts, field sizes and constant values for the arithmetic registers
`ifndef ARITH_CFG_SVH
`define ARITH_CFG_SVH
`define ARITH_WIDTH 44
`define ARITH_DIGITS 11
`define ARITH_NEG_ZERO 44'h80000000000
`define ARITH_UNUSABLE 44'hFFFFFFFFFFF
`define ARITH_MUL_STEPS 11
`endif

// *** core/arith_pkg.sv ***
// Types shared by the arithmetic register datapath
package arith_pkg;
   typedef enum logic [4:0] {
      OP_ADD, OP_ADD_CHK, OP_SUB, OP_SUB_CHK,
      OP_MUL_UP, OP_MUL_UP_CHK, OP_MUL_LO, OP_MUL_LO_CHK,
      OP_DIV_Q, OP_DIV_Q_CHK, OP_DIV_R, OP_DIV_R_CHK,
      OP_MASK, OP_CMP, OP_ZSUP, OP_LNORM, OP_SUBST,
      OP_JMP_PLUS, OP_JMP_MINUS, OP_JMP_ZERO, OP_JMP_UNCOND, OP_XFER
   } arith_op_e;
   typedef enum logic [1:0] {BR_PLUS, BR_ZERO, BR_MINUS} branch_e;
   typedef struct packed {
      arith_op_e op;
      logic [43:0] load_a;
      logic [43:0] load_b;
      logic [43:0] load_c;
      logic [43:0] src;
   } arith_cmd_s;
   typedef struct packed {
      logic [43:0] a;
      logic [43:0] b;
      logic [43:0] c;
      logic [43:0] d;
      logic [43:0] store;
      branch_e br;
   } arith_view_s;
endpackage

// *** core/arith_regs.sv ***
// Four arithmetic registers driven by the instruction sequencer
`include "arith_cfg.svh"
module arith_regs
#(
   parameter int W = `ARITH_WIDTH
)
(
   input wire logic mclk, // 250 MHz clock
   input wire logic srst, // Synchronous reset, high
   input wire logic start, // Begin command, one cycle
   input wire arith_pkg::arith_cmd_s cmd, // Command and operands
   output logic busy, // Command in progress
   output logic done, // Result valid, one cycle
   output arith_pkg::arith_view_s view // Register contents
);
   import arith_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_MUL, S_DIV, S_FIN} st_e;

   st_e st_r, st_nxt;
   logic [W-1:0] a_r, a_nxt, b_r, b_nxt, c_r, c_nxt, d_r, d_nxt;
   logic [W-1:0] st_val_r, st_val_nxt;
   branch_e br_r, br_nxt;
   arith_op_e op_r, op_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic [2*W-1:0] acc_r, acc_nxt;
   logic done_r, done_nxt;

   function automatic logic is_chk(arith_op_e o);
      return o == OP_ADD_CHK || o == OP_SUB_CHK || o == OP_MUL_UP_CHK
         || o == OP_MUL_LO_CHK || o == OP_DIV_Q_CHK || o == OP_DIV_R_CHK;
   endfunction

   function automatic logic stores_c(arith_op_e o);
      return o == OP_MUL_UP || o == OP_MUL_UP_CHK || o == OP_DIV_R
         || o == OP_DIV_R_CHK;
   endfunction

   // Magnitude of a sign-magnitude word
   function automatic logic [W-1:0] mag(logic [W-1:0] v);
      return {1'b0, v[W-2:0]};
   endfunction

   always_comb
   begin
      st_nxt = st_r;
      a_nxt = a_r;
      b_nxt = b_r;
      c_nxt = c_r;
      d_nxt = d_r;
      st_val_nxt = st_val_r;
      br_nxt = br_r;
      op_nxt = op_r;
      cnt_nxt = cnt_r;
      acc_nxt = acc_r;
      done_nxt = 1'b0;
      case (st_r)
         S_IDLE:
         begin
            if (start)
            begin
               op_nxt = cmd.op;
               a_nxt = cmd.load_a;
               b_nxt = cmd.load_b;
               case (cmd.op)
                  OP_ADD, OP_ADD_CHK:
                  begin
                     d_nxt = cmd.load_a + cmd.load_b;
                     c_nxt = is_chk(cmd.op) ? `ARITH_NEG_ZERO
                        : `ARITH_UNUSABLE;
                     st_nxt = S_FIN;
                  end
                  OP_SUB, OP_SUB_CHK:
                  begin
                     d_nxt = cmd.load_a - cmd.load_b;
                     c_nxt = is_chk(cmd.op) ? `ARITH_NEG_ZERO
                        : `ARITH_UNUSABLE;
                     st_nxt = S_FIN;
                  end
                  OP_MUL_UP, OP_MUL_UP_CHK, OP_MUL_LO, OP_MUL_LO_CHK:
                  begin
                     // Shift-add keeps one adder instead of a wide multiplier
                     acc_nxt = '0;
                     cnt_nxt = '0;
                     st_nxt = S_MUL;
                  end
                  OP_DIV_Q, OP_DIV_Q_CHK, OP_DIV_R, OP_DIV_R_CHK:
                  begin
                     c_nxt = cmd.load_c;
                     acc_nxt = {{W{1'b0}}, cmd.load_c};
                     cnt_nxt = '0;
                     st_nxt = S_DIV;
                  end
                  OP_MASK:
                  begin
                     c_nxt = cmd.load_a & cmd.load_b;
                     d_nxt = cmd.load_a & cmd.load_b;
                     st_nxt = S_FIN;
                  end
                  OP_CMP:
                  begin
                     if (cmd.load_a == cmd.load_b)
                        br_nxt = BR_ZERO;
                     else if (cmd.load_a > cmd.load_b)
                        br_nxt = BR_PLUS;
                     else
                        br_nxt = BR_MINUS;
                     st_nxt = S_FIN;
                  end
                  OP_ZSUP:
                  begin
                     b_nxt = b_r;
                     a_nxt = mag(cmd.load_a);
                     d_nxt = mag(cmd.load_a);
                     st_nxt = S_FIN;
                  end
                  OP_LNORM:
                  begin
                     a_nxt = cmd.load_a;
                     b_nxt = '0;
                     acc_nxt = {{W{1'b0}}, cmd.load_a};
                     cnt_nxt = '0;
                     st_nxt = S_MUL;
                  end
                  OP_SUBST:
                  begin
                     c_nxt = cmd.load_b;
                     d_nxt = cmd.load_b;
                     st_nxt = S_FIN;
                  end
                  OP_JMP_PLUS, OP_JMP_MINUS, OP_JMP_ZERO, OP_JMP_UNCOND:
                  begin
                     a_nxt = a_r;
                     b_nxt = b_r;
                     c_nxt = `ARITH_UNUSABLE;
                     st_nxt = S_FIN;
                  end
                  OP_XFER:
                  begin
                     a_nxt = a_r;
                     b_nxt = b_r;
                     d_nxt = cmd.src;
                     st_nxt = S_FIN;
                  end
                  default:
                  begin
                     a_nxt = a_r;
                     b_nxt = b_r;
                  end
               endcase
            end
         end
         S_MUL:
         begin
            if (op_r == OP_LNORM)
            begin
               // Shift left one bit per cycle until the top bit is set or the word is zero
               if (acc_r[W-1] || acc_r[W-1:0] == '0 || cnt_r == 6'(W))
               begin
                  a_nxt = acc_r[W-1:0];
                  d_nxt = acc_r[W-1:0];
                  b_nxt = W'(cnt_r);
                  st_nxt = S_FIN;
               end
               else
               begin
                  acc_nxt = {acc_r[2*W-2:0], 1'b0};
                  cnt_nxt = cnt_r + 6'h01;
               end
            end
            else if (cnt_r == 6'(W))
            begin
               c_nxt = acc_r[2*W-1:W];
               d_nxt = acc_r[W-1:0];
               if (is_chk(op_r))
               begin
                  c_nxt = `ARITH_NEG_ZERO;
                  d_nxt = `ARITH_NEG_ZERO;
               end
               st_nxt = S_FIN;
            end
            else
            begin
               if (b_r[cnt_r[5:0]])
                  acc_nxt = acc_r + ((2*W)'(a_r) << cnt_r);
               cnt_nxt = cnt_r + 6'h01;
            end
         end
         S_DIV:
         begin
            a_nxt = `ARITH_UNUSABLE;
            b_nxt = `ARITH_UNUSABLE;
            if (b_r == '0)
            begin
               c_nxt = '0;
               d_nxt = '0;
            end
            else if (a_r < b_r && c_r < b_r)
            begin
               c_nxt = a_r;
               d_nxt = '0;
            end
            else
            begin
               // Dividend spans C (upper word) and A (lower word)
               c_nxt = W'({c_r, a_r} % {{W{1'b0}}, b_r});
               d_nxt = W'({c_r, a_r} / {{W{1'b0}}, b_r});
               if (is_chk(op_r))
               begin
                  c_nxt = `ARITH_UNUSABLE;
                  d_nxt = `ARITH_UNUSABLE;
               end
            end
            st_nxt = S_FIN;
         end
         S_FIN:
         begin
            st_val_nxt = stores_c(op_r) ? c_r : d_r;
            if (op_r == OP_CMP)
               st_val_nxt = d_r;
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
         end
         default:
            st_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st_r <= S_IDLE;
         a_r <= '0;
         b_r <= '0;
         c_r <= '0;
         d_r <= '0;
         st_val_r <= '0;
         br_r <= BR_ZERO;
         op_r <= OP_ADD;
         cnt_r <= '0;
         acc_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         a_r <= a_nxt;
         b_r <= b_nxt;
         c_r <= c_nxt;
         d_r <= d_nxt;
         st_val_r <= st_val_nxt;
         br_r <= br_nxt;
         op_r <= op_nxt;
         cnt_r <= cnt_nxt;
         acc_r <= acc_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy = (st_r != S_IDLE);
   assign done = done_r;
   assign view = '{a: a_r, b: b_r, c: c_r, d: d_r, store: st_val_r,
                   br: br_r};

   a_add_sum: assert property (@(posedge mclk) disable iff (srst)
      (start && !busy && cmd.op == OP_ADD) |=> ##1
      (view.store == $past(cmd.load_a, 2) + $past(cmd.load_b, 2)))
      else $error("add store mismatch");
   a_chk_negz: assert property (@(posedge mclk) disable iff (srst)
      (start && !busy && cmd.op == OP_ADD_CHK) |=>
      (c_r == `ARITH_NEG_ZERO))
      else $error("checked add C not negative zero");
   a_sub_keep: assert property (@(posedge mclk) disable iff (srst)
      (start && !busy && cmd.op == OP_SUB) |=>
      (a_r == $past(cmd.load_a) && b_r == $past(cmd.load_b)))
      else $error("subtract changed operands");
   a_cmp_hold: assert property (@(posedge mclk) disable iff (srst)
      (start && !busy && cmd.op == OP_CMP) |=> ##1
      (d_r == $past(d_r, 2) && c_r == $past(c_r, 2)))
      else $error("compare changed registers");
   a_jump_c: assert property (@(posedge mclk) disable iff (srst)
      (start && !busy && cmd.op == OP_JMP_UNCOND) |=>
      (c_r == `ARITH_UNUSABLE && d_r == $past(d_r)))
      else $error("jump register use wrong");
   a_xfer_d: assert property (@(posedge mclk) disable iff (srst)
      (start && !busy && cmd.op == OP_XFER) |=> ##1
      (view.store == $past(cmd.src, 2) && done))
      else $error("transfer not stored from D");
   a_div_zero: assert property (@(posedge mclk) disable iff (srst)
      (st_r == S_DIV && b_r == '0) |=> (c_r == '0 && d_r == '0))
      else $error("zero divisor not zeroed");
   a_mask_cd: assert property (@(posedge mclk) disable iff (srst)
      (start && !busy && cmd.op == OP_MASK) |=> (c_r == d_r))
      else $error("mask result differs in C and D");
endmodule

// *** testbench/arith_regs_tb.sv ***
// Self-checking bench for the arithmetic register datapath
`include "arith_cfg.svh"
module arith_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import arith_pkg::*;
   localparam logic [43:0] UN = `ARITH_UNUSABLE;
   localparam logic [43:0] NZ = `ARITH_NEG_ZERO;
   localparam logic [43:0] OA = 44'h123456789AB;
   localparam logic [43:0] OB = 44'h00000ABCDEF;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic start = 1'b0;
   arith_cmd_s cmd = '0;
   logic busy;
   logic done;
   arith_view_s view;
   arith_view_s pv;
   int mismatches = 0;
   int compares = 0;

   always #2 mclk = ~mclk;

   arith_regs #(.W(44)) u_arith_regs
   (
      .mclk(mclk),
      .srst(srst),
      .start(start),
      .cmd(cmd),
      .busy(busy),
      .done(done),
      .view(view)
   );

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [87:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Issue one command; lat below zero skips the latency check.
   // With intr set, a second start is pulsed mid-run and must be ignored.
   task automatic run(input arith_op_e op, input logic [43:0] a, b, c, s,
      input int lat, input bit now = 0, input bit intr = 0);
      int n;
      pv = view;
      if (!now)
         @(negedge mclk);
      cmd = '{op, a, b, c, s};
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      chk("busy", busy, 1);
      // The start cycle is cycle 0, so the cycle after the taking edge is 1
      n = 1;
      while (done !== 1'b1)
      begin
         @(negedge mclk);
         n++;
         start = (intr && n == 5);
         if (intr && n == 5)
            cmd = '{OP_XFER, UN, UN, UN, UN};
         if (n > 200)
         begin
            chk("timeout", 0, 1);
            wrap_up();
         end
      end
      if (lat >= 0)
         chk("latency", n, lat);
      chk("busy_done", busy, 0);
   endtask

   task automatic t_addsub();
      arith_op_e ops[4] = '{OP_ADD, OP_ADD_CHK, OP_SUB, OP_SUB_CHK};
      logic [43:0] r;
      for (int i = 0; i < 4; i++)
      begin
         // Back to back: the next start lands in the done cycle
         run(ops[i], OA, OB, 44'h0, 44'h0, 2, i > 0);
         r = (i < 2) ? OA + OB : OA - OB;
         chk("a", view.a, OA);
         chk("b", view.b, OB);
         chk("d", view.d, r);
         chk("store", view.store, r);
         chk("c", view.c, i[0] ? NZ : UN);
      end
      $display("test addsub done");
   endtask

   task automatic t_mul();
      arith_op_e ops[4] = '{OP_MUL_UP, OP_MUL_UP_CHK, OP_MUL_LO,
         OP_MUL_LO_CHK};
      logic [87:0] p;
      p = {44'h0, OA} * {44'h0, OB};
      for (int i = 0; i < 4; i++)
      begin
         run(ops[i], OA, OB, 44'h0, 44'h0, 47, 0, i == 0);
         chk("a", view.a, OA);
         chk("b", view.b, OB);
         chk("c", view.c, i[0] ? NZ : p[87:44]);
         chk("d", view.d, i[0] ? NZ : p[43:0]);
         chk("store", view.store,
            i[0] ? NZ : (i < 2 ? p[87:44] : p[43:0]));
      end
      $display("test mul done");
   endtask

   task automatic t_div();
      arith_op_e ops[4] = '{OP_DIV_Q, OP_DIV_Q_CHK, OP_DIV_R, OP_DIV_R_CHK};
      for (int i = 0; i < 4; i++)
      begin
         run(ops[i], 44'd100, 44'd7, 44'h0, 44'h0, 3);
         chk("a", view.a, UN);
         chk("b", view.b, UN);
         chk("c", view.c, i[0] ? UN : 44'd2);
         chk("d", view.d, i[0] ? UN : 44'd14);
         chk("store", view.store,
            i[0] ? UN : (i < 2 ? 44'd14 : 44'd2));
         run(ops[i], 44'd100, 44'd0, 44'h0, 44'h0, 3);
         chk("c_zero", view.c, 0);
         chk("d_zero", view.d, 0);
         chk("a_zero", view.a, UN);
         run(ops[i], 44'd5, 44'd9, 44'h0, 44'h0, 3);
         chk("d_small", view.d, 0);
         chk("c_small", view.c, 44'd5);
         chk("b_small", view.b, UN);
      end
      $display("test div done");
   endtask

   task automatic t_misc();
      arith_op_e js[4] = '{OP_JMP_PLUS, OP_JMP_MINUS, OP_JMP_ZERO,
         OP_JMP_UNCOND};
      run(OP_MASK, OA, OB, 44'h0, 44'h0, 2);
      chk("mask_c", view.c, OA & OB);
      chk("mask_d", view.store, OA & OB);
      chk("mask_b", view.b, OB);
      run(OP_SUBST, OA, OB, 44'h0, 44'h0, 2);
      chk("subst_c", view.c, OB);
      chk("subst_d", view.d, OB);
      chk("subst_a", view.a, OA);
      run(OP_CMP, OA, OB, 44'h0, 44'h0, 2);
      chk("cmp_plus", view.br, BR_PLUS);
      chk("cmp_c", view.c, pv.c);
      chk("cmp_d", view.d, pv.d);
      run(OP_CMP, OB, OB, 44'h0, 44'h0, 2);
      chk("cmp_zero", view.br, BR_ZERO);
      run(OP_CMP, OB, OA, 44'h0, 44'h0, 2);
      chk("cmp_minus", view.br, BR_MINUS);
      chk("cmp_a", view.a, OB);
      run(OP_ZSUP, 44'h80000000123, 44'h0, 44'h0, 44'h0, 2);
      chk("zs_a", view.a, 44'h123);
      chk("zs_d", view.store, 44'h123);
      chk("zs_b", view.b, pv.b);
      // Top set bit 11 moves to bit 43: 32 shifts, done 35 cycles on
      run(OP_LNORM, 44'h00000000F00, 44'h0, 44'h0, 44'h0, 35);
      chk("ln_a", view.a, 44'hF0000000000);
      chk("ln_d", view.d, 44'hF0000000000);
      chk("ln_b", view.b, 44'd32);
      chk("ln_st", view.store, 44'hF0000000000);
      chk("ln_c", view.c, pv.c);
      for (int i = 0; i < 4; i++)
      begin
         run(js[i], 44'h0, 44'h0, 44'h0, 44'h0, 2);
         chk("jmp_c", view.c, UN);
         chk("jmp_abd", {view.a, view.b, view.d},
            {pv.a, pv.b, pv.d});
      end
      run(OP_XFER, 44'h0, 44'h0, 44'h0, 44'h5A5A5A5A5A5, 2);
      chk("xfer_d", view.store, 44'h5A5A5A5A5A5);
      chk("xfer_abc", {view.a, view.b, view.c},
         {pv.a, pv.b, pv.c});
      $display("test misc done");
   endtask

   initial
   begin
      repeat (3) @(negedge mclk);
      chk("rst_regs", {view.a, view.b, view.c, view.d}, 0);
      chk("rst_br", view.br, BR_ZERO);
      chk("rst_flags", {busy, done}, 0);
      srst = 1'b0;
      $display("test reset done");
      t_addsub();
      t_mul();
      t_div();
      t_misc();
      wrap_up();
   end
endmodule
